// ---- design/pib_pkg.sv ----
// Package: register map, field positions and reset values for input blanking
package pib_pkg;
    // Register byte offsets on the AXI4-Lite bus
    localparam logic [3:0] PIB_OFS_CONTROL = 4'h0;
    localparam logic [3:0] PIB_OFS_DELAY = 4'h4;
    localparam logic [3:0] PIB_OFS_AUX = 4'h8;
    localparam logic [3:0] PIB_OFS_STATUS = 4'hc;

    // Control register field positions
    localparam int PIB_HRISE_BIT = 15;
    localparam int PIB_HFALL_BIT = 14;
    localparam int PIB_LRISE_BIT = 13;
    localparam int PIB_LFALL_BIT = 12;
    localparam int PIB_FLTLEB_BIT = 11;
    localparam int PIB_CLLEB_BIT = 10;
    localparam int PIB_EXTH_BIT = 5;
    localparam int PIB_EXTL_BIT = 4;
    localparam int PIB_HOH_BIT = 3;
    localparam int PIB_HOL_BIT = 2;
    localparam int PIB_LOH_BIT = 1;
    localparam int PIB_LOL_BIT = 0;

    // Writable masks; the other bits read as zero
    localparam logic [15:0] PIB_CONTROL_MASK = 16'hfc3f;
    localparam logic [15:0] PIB_DELAY_MASK = 16'h0fff;
    localparam logic [15:0] PIB_AUX_MASK = 16'h0f00;
    localparam int PIB_SEL_LSB = 8;

    // Reset values
    localparam logic [15:0] PIB_CONTROL_RST = 16'h0000;
    localparam logic [15:0] PIB_DELAY_RST = 16'h0000;
    localparam logic [15:0] PIB_AUX_RST = 16'h0000;

    localparam int PIB_DLY_W = 12;
    localparam int PIB_NUM_SRC = 6;

    localparam logic [1:0] PIB_RESP_OKAY = 2'h0;
    localparam logic [1:0] PIB_RESP_SLVERR = 2'h2;
endpackage : pib_pkg

// ---- design/pib_edge_timer.sv ----
// Leading-edge blanking delay counter
`timescale 1ns/1ps
`default_nettype none
module pib_edge_timer
    import pib_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic start_i,
    input wire logic [PIB_DLY_W-1:0] delay_i,
    output logic active_o,
    output logic [PIB_DLY_W-1:0] count_o
);
    logic [PIB_DLY_W-1:0] count;
    logic [PIB_DLY_W-1:0] next_count;

    assign next_count = start_i ? delay_i :
        (count != '0) ? count - 1'b1 : count;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign active_o = (count != '0);
    assign count_o = count;
endmodule : pib_edge_timer
`default_nettype wire

// ---- design/pib_blanking.sv ----
// Leading-edge and state blanking of fault and current-limit inputs
// Behaviour
// - High rising edge starts delay when enabled
// - High falling edge starts delay when enabled
// - Low rising edge starts delay when enabled
// - Low falling edge starts delay when enabled
// - Fault enable gates edge blanking on fault
// - Limit enable gates edge blanking on limit
// - Mask while selected source is high
// - Mask while selected source is low
// - Mask while high output is high
// - Mask while high output is low
// - Mask while low output is high
// - Mask while low output is low
// - Twelve-bit delay field sets blanking length
// - Unused bits ignore writes, read zero
// - External source chosen by auxiliary select
// - Code zero none, one-six generator highs
`timescale 1ns/1ps
`default_nettype none
module pib_blanking
    import pib_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    // AXI4-Lite slave
    input wire logic [3:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [3:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // Generator outputs, same clock domain
    input wire logic gen_high_output_i,
    input wire logic gen_low_output_i,
    // High outputs of generators one through six, asynchronous
    input wire logic [PIB_NUM_SRC-1:0] blank_src_i,
    // Selected fault and current-limit inputs, active high
    input wire logic fault_i,
    input wire logic climit_i,
    output logic fault_o,
    output logic climit_o
);
    ////////////////////////////////////////////////////////////////////
    // Registers and bus slave
    logic [15:0] blanking_control;
    logic [15:0] blanking_delay_value;
    logic [15:0] auxiliary_control;
    logic [3:0] aw_addr;
    logic aw_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_held;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;

    wire aw_take = s_axi_awvalid_i && s_axi_awready_o;
    wire w_take = s_axi_wvalid_i && s_axi_wready_o;
    wire do_write = aw_held && w_held && !bvalid;
    wire wr_ctl = do_write && (aw_addr == PIB_OFS_CONTROL);
    wire wr_dly = do_write && (aw_addr == PIB_OFS_DELAY);
    wire wr_aux = do_write && (aw_addr == PIB_OFS_AUX);
    wire wr_hit = wr_ctl || wr_dly || wr_aux;
    wire [15:0] lane_mask = {{8{w_strb[1]}}, {8{w_strb[0]}}};
    wire ar_take = s_axi_arvalid_i && s_axi_arready_o;

    assign s_axi_awready_o = !aw_held;
    assign s_axi_wready_o = !w_held;
    assign s_axi_arready_o = !rvalid;
    assign s_axi_bvalid_o = bvalid;
    assign s_axi_bresp_o = bresp;
    assign s_axi_rvalid_o = rvalid;
    assign s_axi_rdata_o = rdata;
    assign s_axi_rresp_o = rresp;

    function automatic logic [15:0] merge(input logic [15:0] old,
        input logic [15:0] wd, input logic [15:0] lanes,
        input logic [15:0] keep);
        merge = ((old & ~lanes) | (wd & lanes)) & keep;
    endfunction : merge

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            aw_held <= 1'b0;
            aw_addr <= 4'h0;
        end else if (aw_take) begin
            aw_held <= 1'b1;
            aw_addr <= {s_axi_awaddr_i[3:2], 2'b00};
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (w_take) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata_i;
            w_strb <= s_axi_wstrb_i;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            bvalid <= 1'b0;
            bresp <= PIB_RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp <= wr_hit ? PIB_RESP_OKAY : PIB_RESP_SLVERR;
        end else if (s_axi_bready_i) begin
            bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            blanking_control <= PIB_CONTROL_RST;
            blanking_delay_value <= PIB_DELAY_RST;
            auxiliary_control <= PIB_AUX_RST;
        end else begin
            if (wr_ctl) begin
                blanking_control <= merge(blanking_control, w_data[15:0],
                    lane_mask, PIB_CONTROL_MASK);
            end
            if (wr_dly) begin
                blanking_delay_value <= merge(blanking_delay_value,
                    w_data[15:0], lane_mask, PIB_DELAY_MASK);
            end
            if (wr_aux) begin
                auxiliary_control <= merge(auxiliary_control, w_data[15:0],
                    lane_mask, PIB_AUX_MASK);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read path
    logic edge_active;
    logic [PIB_DLY_W-1:0] edge_count;
    logic fault_mask;
    logic climit_mask;
    wire [3:0] rd_addr = {s_axi_araddr_i[3:2], 2'b00};
    wire rd_hit = (rd_addr == PIB_OFS_CONTROL) || (rd_addr == PIB_OFS_DELAY)
        || (rd_addr == PIB_OFS_AUX) || (rd_addr == PIB_OFS_STATUS);
    // Status: counter value, edge active, fault mask, limit mask
    wire [15:0] status_word = {1'b0, climit_mask, fault_mask, edge_active,
        edge_count};
    wire [15:0] rd_word = (rd_addr == PIB_OFS_CONTROL) ? blanking_control :
        (rd_addr == PIB_OFS_DELAY) ? blanking_delay_value :
        (rd_addr == PIB_OFS_AUX) ? auxiliary_control :
        (rd_addr == PIB_OFS_STATUS) ? status_word : 16'h0000;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= PIB_RESP_OKAY;
        end else if (ar_take) begin
            rvalid <= 1'b1;
            rdata <= {16'h0000, rd_word};
            rresp <= rd_hit ? PIB_RESP_OKAY : PIB_RESP_SLVERR;
        end else if (s_axi_rready_i) begin
            rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Edge detection and blanking timer
    logic high_prev;
    logic low_prev;
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            high_prev <= 1'b0;
            low_prev <= 1'b0;
        end else begin
            high_prev <= gen_high_output_i;
            low_prev <= gen_low_output_i;
        end
    end

    wire high_rise = gen_high_output_i && !high_prev;
    wire high_fall = !gen_high_output_i && high_prev;
    wire low_rise = gen_low_output_i && !low_prev;
    wire low_fall = !gen_low_output_i && low_prev;
    wire edge_start = (high_rise && blanking_control[PIB_HRISE_BIT])
        || (high_fall && blanking_control[PIB_HFALL_BIT])
        || (low_rise && blanking_control[PIB_LRISE_BIT])
        || (low_fall && blanking_control[PIB_LFALL_BIT]);

    pib_edge_timer u_timer (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .start_i(edge_start),
        .delay_i(blanking_delay_value[PIB_DLY_W-1:0]),
        .active_o(edge_active),
        .count_o(edge_count)
    );

    ////////////////////////////////////////////////////////////////////
    // External state blanking source; other generators are async
    logic [PIB_NUM_SRC-1:0] src_meta;
    logic [PIB_NUM_SRC-1:0] src_sync;
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            src_meta <= '0;
            src_sync <= '0;
        end else begin
            src_meta <= blank_src_i;
            src_sync <= src_meta;
        end
    end

    wire [3:0] blank_source_select = auxiliary_control[PIB_SEL_LSB +: 4];
    wire sel_valid = (blank_source_select != 4'h0)
        && (blank_source_select <= 4'h6);
    wire [2:0] sel_idx = 3'(blank_source_select - 4'h1);
    wire ext_level = src_sync[sel_idx];

    wire ext_blank = sel_valid
        && ((blanking_control[PIB_EXTH_BIT] && ext_level)
        || (blanking_control[PIB_EXTL_BIT] && !ext_level));
    wire out_blank = (blanking_control[PIB_HOH_BIT] && gen_high_output_i)
        || (blanking_control[PIB_HOL_BIT] && !gen_high_output_i)
        || (blanking_control[PIB_LOH_BIT] && gen_low_output_i)
        || (blanking_control[PIB_LOL_BIT] && !gen_low_output_i);
    wire state_blank = ext_blank || out_blank;

    assign fault_mask = state_blank
        || (edge_active && blanking_control[PIB_FLTLEB_BIT]);
    assign climit_mask = state_blank
        || (edge_active && blanking_control[PIB_CLLEB_BIT]);

    // Registered outputs; one cycle of latency traded for clean edges
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            fault_o <= 1'b0;
            climit_o <= 1'b0;
        end else begin
            fault_o <= fault_i && !fault_mask;
            climit_o <= climit_i && !climit_mask;
        end
    end
endmodule : pib_blanking
`default_nettype wire

// ---- verif/pib_blanking_props.sv ----
// Checker: bus handshake and blanked-input properties of the block
`timescale 1ns/1ps
`default_nettype none
module pib_blanking_props (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic fault_i,
    input wire logic climit_i,
    input wire logic fault_o,
    input wire logic climit_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    sequence s_wr_take;
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid_i && s_axi_arready_o;
    endsequence
    chk_wr_answer: assert property (s_wr_take |-> ##[1:2] s_axi_bvalid_o)
        else $error("write response missing");
    chk_b_done: assert property (s_axi_bvalid_o && s_axi_bready_i |=>
        !s_axi_bvalid_o) else $error("bvalid not released");
    chk_rd_answer: assert property (s_rd_take |=> s_axi_rvalid_o)
        else $error("read data missing");
    chk_ar_block: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
        else $error("read taken while data pending");
    chk_r_done: assert property (s_axi_rvalid_o && s_axi_rready_i |=>
        !s_axi_rvalid_o) else $error("rvalid not released");
    chk_rd_upper: assert property (s_axi_rvalid_o |->
        s_axi_rdata_o[31:16] == 16'h0) else $error("upper read bits set");
    chk_fault_pass: assert property (fault_o |-> $past(fault_i))
        else $error("fault out without fault in");
    chk_limit_pass: assert property (climit_o |-> $past(climit_i))
        else $error("limit out without limit in");
endmodule : pib_blanking_props
bind pib_blanking pib_blanking_props u_props (.*);
`default_nettype wire

// ---- verif/pib_gen_model.sv ----
// Partner: generator outputs and comparator sources, one cycle behind
`timescale 1ns/1ps
`default_nettype none
module pib_gen_model (
    input wire logic clk_i,
    input wire logic [9:0] set_i,
    output logic high_o,
    output logic low_o,
    output logic [5:0] src_o,
    output logic fault_o,
    output logic climit_o
);
    // Levels move only on the clock, as the generator's own flops do
    always_ff @(posedge clk_i) begin
        {high_o, low_o, src_o, fault_o, climit_o} <= set_i;
    end
endmodule : pib_gen_model
`default_nettype wire

// ---- verif/tb_top.sv ----
// Testbench: register access, edge blanking and state blanking
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pib_pkg::*;
    logic clk_i = 0, nrst_i = 0, aw_v = 0, w_v = 0, b_r = 0, ar_v = 0;
    logic r_r = 0, aw_rdy, w_rdy, b_v, ar_rdy, r_v, f_o, c_o, hi, lo, flt, cl;
    logic [3:0] aw_a = 0, ar_a = 0;
    logic [31:0] w_d = 0, r_d, rv;
    logic [1:0] b_resp, r_resp;
    logic [5:0] src, one;
    // Target levels {high, low, sources, fault, limit}
    logic [9:0] tgt = 10'h3;
    logic [31:0] exp_q[$];
    logic [3:0] ofs[3] = '{PIB_OFS_CONTROL, PIB_OFS_DELAY, PIB_OFS_AUX};
    logic [15:0] msk[3] = '{PIB_CONTROL_MASK, PIB_DELAY_MASK, PIB_AUX_MASK};
    int errors = 0, tests_run = 0, seed = 32'hed39, b;
    initial forever #20 clk_i = ~clk_i;
    pib_blanking dut (.clk_i(clk_i), .nrst_i(nrst_i), .s_axi_awaddr_i(aw_a),
        .s_axi_awvalid_i(aw_v), .s_axi_awready_o(aw_rdy), .s_axi_wdata_i(w_d),
        .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(w_v), .s_axi_wready_o(w_rdy),
        .s_axi_bresp_o(b_resp), .s_axi_bvalid_o(b_v), .s_axi_bready_i(b_r),
        .s_axi_araddr_i(ar_a), .s_axi_arvalid_i(ar_v),
        .s_axi_arready_o(ar_rdy), .s_axi_rdata_o(r_d), .s_axi_rresp_o(r_resp),
        .s_axi_rvalid_o(r_v), .s_axi_rready_i(r_r), .gen_high_output_i(hi),
        .gen_low_output_i(lo), .blank_src_i(src), .fault_i(flt),
        .climit_i(cl), .fault_o(f_o), .climit_o(c_o));
    pib_gen_model u_gen (.clk_i(clk_i), .set_i(tgt), .high_o(hi),
        .low_o(lo), .src_o(src), .fault_o(flt), .climit_o(cl));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e, s);
        tests_run++;
        if (s !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        bit at, wt;
        aw_a <= a;
        w_d <= {16'h0, d};
        aw_v <= 1;
        w_v <= 1;
        b_r <= 1;
        // Address and data are released separately, each when taken
        do begin
            @(posedge clk_i);
            if (aw_rdy && !at) begin at = 1; aw_v <= 0; end
            if (w_rdy && !wt) begin wt = 1; w_v <= 0; end
        end while (!(at && wt));
        // Ready stays high so back-to-back calls never toggle it in one step
        do @(posedge clk_i); while (!b_v);
        chk("bresp", {30'h0, PIB_RESP_OKAY}, {30'h0, b_resp});
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        ar_a <= a;
        ar_v <= 1;
        r_r <= 1;
        exp_q.push_back(e);
        do @(posedge clk_i); while (!ar_rdy);
        ar_v <= 0;
        do @(posedge clk_i); while (!r_v);
    endtask : rd
    task automatic cf(input logic fb, cb);
        chk("fault_o", {31'h0, !fb}, {31'h0, f_o});
        chk("climit_o", {31'h0, !cb}, {31'h0, c_o});
    endtask : cf
    always @(posedge clk_i) begin
        if (nrst_i && r_v && r_r) begin
            chk("rdata", exp_q.pop_front(), r_d);
            chk("rresp", {30'h0, PIB_RESP_OKAY}, {30'h0, r_resp});
        end
    end
    task automatic summarize;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize
    initial begin
        tick(2500);
        errors++;
        summarize();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        tick(4);
        nrst_i <= 1;
        rd(PIB_OFS_STATUS, 32'h0);
        for (int k = 0; k < 3; k++) begin
            rd(ofs[k], 32'h0);
            rv = (k == 1) ? 32'hffff : $random(seed);
            wr(ofs[k], rv[15:0]);
            rd(ofs[k], {16'h0, rv[15:0] & msk[k]});
        end
        wr(PIB_OFS_DELAY, 16'h6);
        for (int i = 0; i < 4; i++) begin
            b = (i < 2) ? 9 : 8;
            tgt[b] <= i[0];
            wr(PIB_OFS_CONTROL, (16'h8000 >> i) | (i[0] ? 16'h0800 : 16'h0400));
            tick(6);
            tgt[b] <= !i[0];
            tick(5);
            cf(i[0], !i[0]);
            tick(6);
            cf(0, 0);
            tgt[b] <= i[0];
            tick(5);
            cf(0, 0);
        end
        for (int j = 0; j < 4; j++) begin
            b = (j >= 2) ? 9 : 8;
            tgt[b] <= j[0];
            wr(PIB_OFS_CONTROL, 16'h1 << j);
            tick(7);
            cf(1, 1);
            tgt[b] <= !j[0];
            tick(7);
            cf(0, 0);
        end
        for (int s = 0; s < 7; s++) begin
            one = (s == 0) ? 6'h0 : 6'h1 << (s - 1);
            wr(PIB_OFS_AUX, 16'(s) << PIB_SEL_LSB);
            for (int p = 0; p < 2; p++) begin
                rv = $random(seed);
                wr(PIB_OFS_CONTROL, p ? 16'h0010 : 16'h0020);
                tgt[7:2] <= p ? (rv[5:0] & ~one) : (rv[5:0] | one);
                tick(7);
                cf(s != 0, s != 0);
            end
        end
        summarize();
    end
endmodule : tb_top
`default_nettype wire
